// *** acf_cell_port.sv ***
// Transmit cell FIFO system port with receive output gating and registers
//
// How it works
// - Float enable high: drive outputs only when reading
// - Float enable low: receive outputs always driven
// - Sample write inputs on FIFO clock rising edge
// - Enable low at edge stores one word unless the FIFO is full
// - Enable high at edge leaves FIFO alone
// - Data counts only with enable asserted
// - Cell leaves FIFO only when fully written
// - No full cell at slot: send idle
// - Space flag changes only at FIFO clock edges
// - First-word marker elsewhere raises an interrupt
// - Word or byte parity, odd or even
// - Space flag: full or near-full, programmable polarity
// - Space flag high while in reset
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module acf_cell_port #(
  parameter int WORDS_PER_CELL = acf_pkg::WORDS_PER_CELL_DEF,
  parameter int FIFO_DEPTH = acf_pkg::FIFO_DEPTH_DEF,
  parameter logic [15:0] IDLE_FILL_WORD = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic tx_fifo_clk,
  input wire logic tx_write_enable_n,
  input wire logic tx_cell_first_word,
  input wire logic [1:0] tx_word_parity,
  input wire logic [15:0] tx_cell_word,
  output logic tx_space_available,
  input wire logic rx_output_float_enable,
  input wire logic rx_read_enable_n,
  input wire acf_pkg::acf_word_s rx_src,
  output logic [15:0] rx_cell_word,
  output logic [1:0] rx_word_parity,
  output logic rx_cell_first_word,
  output logic rx_out_oe,
  input wire logic cell_slot,
  output acf_pkg::acf_out_s payload_word,
  output logic payload_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic irq
);

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam int CW = $clog2(WORDS_PER_CELL + 1);
  localparam int NCELLS = FIFO_DEPTH / WORDS_PER_CELL;
  localparam int NW = $clog2(NCELLS + 1);
  localparam logic [LW-1:0] DEPTH_L = LW'(FIFO_DEPTH);
  localparam logic [LW-1:0] NEAR_L = LW'(FIFO_DEPTH - acf_pkg::NEAR_FULL_WRITES);
  localparam logic [CW-1:0] LAST_WORD = CW'(WORDS_PER_CELL - 1);
  localparam logic [AW-1:0] LAST_IDX = AW'(FIFO_DEPTH - 1);

  // Drain state machine, one-hot
  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_SEND = 2'b10
  } acf_drain_e;

  // Expected parity pair for a word under the current mode
  function automatic logic [1:0] acf_parity(input logic [15:0] d,
                                            input logic byte_mode,
                                            input logic odd);
    logic [1:0] p;
    p = 2'b00;
    if (byte_mode) begin
      p[1] = (^d[15:8]) ^ odd;
      p[0] = (^d[7:0]) ^ odd;
    end else begin
      p[1] = (^d) ^ odd;
      p[0] = 1'b0;
    end
    return p;
  endfunction

  // Wrapping index step shared by both pointers
  function automatic logic [AW-1:0] acf_next_idx(input logic [AW-1:0] i);
    return (i == LAST_IDX) ? '0 : i + AW'(1);
  endfunction

  // ---------------- Pin synchronisation ----------------
  localparam int TXW = 3 + $bits(acf_pkg::acf_word_s);
  logic [TXW-1:0] tx_pins; // Raw transmit pins bundled
  logic [TXW-1:0] tx_sync; // Agreed transmit pins
  logic [1:0] rx_ctl_sync; // Agreed float enable and read enable
  logic tx_clk_lvl_q; // Last accepted FIFO clock level
  logic tx_edge; // One-cycle pulse per FIFO clock rising edge
  logic tx_wen_n;
  acf_pkg::acf_word_s tx_in;

  assign tx_pins = {tx_fifo_clk, tx_write_enable_n, 1'b0, tx_cell_first_word,
                    tx_word_parity, tx_cell_word};

  // Clock and data go through the same stages so they stay aligned
  acf_sync3 #(.W(TXW), .RST_VAL({1'b0, 1'b1, {(TXW-2){1'b0}}})) u_tx_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .d(tx_pins),
    .q(tx_sync)
  );

  // Read enable idles high but float enable idles low, so the bus is driven after reset until the pins sync
  acf_sync3 #(.W(2), .RST_VAL(2'b01)) u_rx_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .d({rx_output_float_enable, rx_read_enable_n}),
    .q(rx_ctl_sync)
  );

  assign tx_wen_n = tx_sync[TXW-2];
  assign tx_in = tx_sync[$bits(acf_pkg::acf_word_s)-1:0];

  // Rising edge of the writer's clock as seen after synchronising
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_clk_lvl_q <= 1'b0;
    end else if (clk_en) begin
      tx_clk_lvl_q <= tx_sync[TXW-1];
    end
  end
  // Limitation: the writer's clock must be far below ref_clk to be seen
  assign tx_edge = clk_en & tx_sync[TXW-1] & ~tx_clk_lvl_q;

  // ---------------- Registers ----------------
  logic [acf_pkg::CTRL_W-1:0] ctrl_q; // Mode bits
  logic [acf_pkg::ST_W-1:0] status_q; // Sticky events
  logic [acf_pkg::ST_W-1:0] mask_q; // Interrupt enables
  logic [acf_pkg::ST_W-1:0] ev; // Event pulses this cycle
  logic [31:0] rdata_q;
  logic [LW-1:0] level_q; // Words held
  logic [NW-1:0] cells_q; // Complete cells held

  // Control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= acf_pkg::CTRL_RST;
    end else if (clk_en && reg_we && reg_addr == acf_pkg::REG_CTRL) begin
      ctrl_q <= reg_wdata[acf_pkg::CTRL_W-1:0];
    end
  end

  // Mask register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= acf_pkg::MASK_RST;
    end else if (clk_en && reg_we && reg_addr == acf_pkg::REG_MASK) begin
      mask_q <= reg_wdata[acf_pkg::ST_W-1:0];
    end
  end

  // Status: write one to clear; a same-cycle event wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= acf_pkg::ST_RST;
    end else if (clk_en) begin
      if (reg_we && reg_addr == acf_pkg::REG_STATUS) begin
        status_q <= (status_q & ~reg_wdata[acf_pkg::ST_W-1:0]) | ev;
      end else begin
        status_q <= status_q | ev;
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= 32'h0000_0000;
      if (reg_re) begin
        case (reg_addr)
          acf_pkg::REG_CTRL: rdata_q <= 32'(ctrl_q);
          acf_pkg::REG_STATUS: rdata_q <= 32'(status_q);
          acf_pkg::REG_MASK: rdata_q <= 32'(mask_q);
          acf_pkg::REG_LEVEL: begin
            rdata_q <= 32'(level_q) | (32'(cells_q) << acf_pkg::LVL_CELLS_POS);
          end
          default: rdata_q <= 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(status_q & mask_q);

  // ---------------- Transmit write side ----------------
  logic [AW-1:0] wr_idx_q;
  logic [CW-1:0] wr_pos_q; // Word position inside the cell being written
  logic wr_take; // Accepted write this cycle
  logic wr_ovf; // Write dropped for lack of room
  logic cell_done; // Last word of a cell accepted
  logic rd_take; // Word leaves the FIFO this cycle
  logic cell_out; // Last word of a cell left
  logic [AW-1:0] rd_idx_q; // Oldest stored word
  logic [15:0] rd_word; // Word at the read index
  logic [LW-1:0] level_nx; // Level after this cycle's moves
  logic [1:0] par_exp;
  logic par_bad;

  // Only an edge with enable low writes; otherwise data is ignored
  assign wr_take = tx_edge & ~tx_wen_n & (level_q != DEPTH_L);
  assign wr_ovf = tx_edge & ~tx_wen_n & (level_q == DEPTH_L);
  assign cell_done = wr_take & (wr_pos_q == LAST_WORD);

  // Parity check on accepted words only; low bit unused in word mode
  assign par_exp = acf_parity(tx_in.data, ctrl_q[acf_pkg::CTRL_BYTE_PAR],
                              ctrl_q[acf_pkg::CTRL_ODD_PAR]);
  assign par_bad = wr_take & ((par_exp[1] != tx_in.parity[1]) |
                   (ctrl_q[acf_pkg::CTRL_BYTE_PAR] &
                    (par_exp[0] != tx_in.parity[0])));

  acf_fifo_mem #(.W(acf_pkg::WORD_W), .DEPTH(FIFO_DEPTH), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .wr_en(wr_take),
    .wr_idx(wr_idx_q),
    .wr_data(tx_in.data),
    .rd_idx(rd_idx_q),
    .rd_data(rd_word)
  );

  // Write index and cell position; marker is optional on each cell
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_idx_q <= '0;
      wr_pos_q <= '0;
    end else if (wr_take) begin
      wr_idx_q <= acf_next_idx(wr_idx_q);
      wr_pos_q <= (wr_pos_q == LAST_WORD) ? '0 : wr_pos_q + CW'(1);
    end
  end

  // Word level; both ends may move in the same cycle
  assign level_nx = level_q + LW'(wr_take) - LW'(rd_take);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= '0;
    end else if (clk_en) begin
      level_q <= level_nx;
    end
  end

  // Complete cell count gates the drain side
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cells_q <= '0;
    end else if (clk_en) begin
      cells_q <= cells_q + NW'(cell_done) - NW'(cell_out);
    end
  end

  // ---------------- Space flag ----------------
  logic space_raw;
  logic space_q;

  // Threshold on the level after this edge's write, so the flag is never one word late
  assign space_raw = ctrl_q[acf_pkg::CTRL_NEAR_SEL] ? (level_nx < NEAR_L) :
                     (level_nx < DEPTH_L);

  // Updated only on the writer's clock edge so it looks synchronous to it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      space_q <= 1'b1;
    end else if (tx_edge) begin
      space_q <= space_raw ^ ctrl_q[acf_pkg::CTRL_SPACE_LOW];
    end
  end

  // Reset forces the flag high whatever the polarity bit
  assign tx_space_available = space_q | rst;

  // ---------------- Drain toward the payload ----------------
  acf_drain_e st_q;
  logic [CW-1:0] out_pos_q; // Word position of the cell being sent
  logic real_q; // Cell being sent comes from the FIFO
  acf_pkg::acf_out_s out_q;
  logic out_vld_q;
  logic slot_go; // Slot taken this cycle

  assign slot_go = clk_en & cell_slot & (st_q == ST_WAIT);
  assign rd_take = clk_en & (st_q == ST_SEND) & real_q;
  assign cell_out = rd_take & (out_pos_q == LAST_WORD);

  // Slot seen while busy is ignored; the line side must space them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_WAIT;
      out_pos_q <= '0;
      real_q <= 1'b0;
    end else if (clk_en) begin
      case (st_q)
        ST_WAIT: begin
          if (cell_slot) begin
            st_q <= ST_SEND;
            out_pos_q <= '0;
            real_q <= (cells_q != '0);
          end
        end
        ST_SEND: begin
          if (out_pos_q == LAST_WORD) begin
            st_q <= ST_WAIT;
          end else begin
            out_pos_q <= out_pos_q + CW'(1);
          end
        end
        default: st_q <= ST_WAIT;
      endcase
    end
  end

  // Read index advances only for FIFO cells
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_idx_q <= '0;
    end else if (rd_take) begin
      rd_idx_q <= acf_next_idx(rd_idx_q);
    end
  end

  // Registered payload word: FIFO data or idle fill
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_q <= '0;
      out_vld_q <= 1'b0;
    end else if (clk_en) begin
      out_vld_q <= (st_q == ST_SEND);
      out_q.first <= (st_q == ST_SEND) & (out_pos_q == '0);
      out_q.idle <= ~real_q;
      out_q.data <= real_q ? rd_word : IDLE_FILL_WORD;
    end
  end

  assign payload_word = out_q;
  assign payload_valid = out_vld_q;

  // ---------------- Events ----------------
  always_comb begin
    ev = '0;
    ev[acf_pkg::ST_PAR_ERR] = par_bad;
    ev[acf_pkg::ST_MARK_ERR] = wr_take & tx_in.first & (wr_pos_q != '0);
    ev[acf_pkg::ST_OVERFLOW] = wr_ovf;
    ev[acf_pkg::ST_IDLE_SENT] = slot_go & (cells_q == '0);
  end

  // ---------------- Receive output drive ----------------
  logic [15:0] rx_word_q;
  logic [1:0] rx_par_q;
  logic rx_first_q;

  // Outputs from flops; parity regenerated under the current mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_word_q <= 16'h0000;
      rx_par_q <= 2'h0;
      rx_first_q <= 1'b0;
    end else if (clk_en) begin
      rx_word_q <= rx_src.data;
      rx_first_q <= rx_src.first;
      rx_par_q <= acf_parity(rx_src.data, ctrl_q[acf_pkg::CTRL_BYTE_PAR],
                             ctrl_q[acf_pkg::CTRL_ODD_PAR]);
    end
  end

  assign rx_cell_word = rx_word_q;
  assign rx_word_parity = rx_par_q;
  assign rx_cell_first_word = rx_first_q;
  // Gated by read enable in float mode, else always driven
  assign rx_out_oe = ~rx_ctl_sync[1] | ~rx_ctl_sync[0];

endmodule
`default_nettype wire

// *** acf_pkg.sv ***
// Shared constants, register map and word carriers of the cell FIFO port
package acf_pkg;

  // Word and parity widths of the cell buses
  localparam int WORD_W = 16;
  localparam int PAR_W = 2;

  // Default words per 53-octet cell (last word carries one pad octet)
  localparam int WORDS_PER_CELL_DEF = 27;
  // Default transmit FIFO depth in words, four cells
  localparam int FIFO_DEPTH_DEF = 108;
  // Near-full margin: space flag drops when no more than this many writes fit
  localparam int NEAR_FULL_WRITES = 4;
  // Highest transmit FIFO clock the writer may use, in MHz
  localparam int TX_CLK_MAX_MHZ = 52;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_LEVEL = 8'h0c;

  // Control fields
  localparam int CTRL_W = 4;
  localparam int CTRL_BYTE_PAR = 0;
  localparam int CTRL_ODD_PAR = 1;
  localparam int CTRL_NEAR_SEL = 2;
  localparam int CTRL_SPACE_LOW = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Status and mask fields
  localparam int ST_W = 4;
  localparam int ST_PAR_ERR = 0;
  localparam int ST_MARK_ERR = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_IDLE_SENT = 3;
  localparam logic [ST_W-1:0] ST_RST = 4'h0;
  localparam logic [ST_W-1:0] MASK_RST = 4'h0;

  // Level register fields
  localparam int LVL_CELLS_POS = 16;

  // One cell word with its side signals
  typedef struct packed {
    logic first;
    logic [PAR_W-1:0] parity;
    logic [WORD_W-1:0] data;
  } acf_word_s;

  // One word handed to the payload side
  typedef struct packed {
    logic first;
    logic idle;
    logic [WORD_W-1:0] data;
  } acf_out_s;

endpackage

// *** acf_sync3.sv ***
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none
module acf_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q; // Metastable stage, read only by s2
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q; // Accepted value

  // Shift chain; the first stage feeds nothing but the second
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else if (clk_en) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per-bit acceptance once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q_q <= RST_VAL;
    end else if (clk_en) begin
      q_q <= (s2_q & s3_q) | (q_q & (s2_q | s3_q));
    end
  end

  assign q = q_q;

endmodule
`default_nettype wire

// *** acf_fifo_mem.sv ***
// Flip-flop word store of the transmit FIFO, addressed by index
`timescale 1ns/1ns
`default_nettype none
module acf_fifo_mem #(
  parameter int W = 16,
  parameter int DEPTH = 108,
  parameter int AW = 7
) (
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_idx,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem_q [DEPTH]; // Storage, no reset needed for data

  // Write port
  always_ff @(posedge ref_clk) begin
    if (clk_en && wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Read port is plain indexing; the caller registers it
  assign rd_data = mem_q[rd_idx];

endmodule
`default_nettype wire

// *** acf_cell_port_properties.sv ***
// Concurrent checks on the ports of the transmit cell FIFO port
`timescale 1ns/1ns
`default_nettype none
module acf_cp_chk #(
  parameter int WORDS_PER_CELL = 27,
  parameter logic [15:0] IDLE_FILL_WORD = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tx_fifo_clk,
  input wire logic tx_space_available,
  input wire logic rx_output_float_enable,
  input wire logic rx_read_enable_n,
  input wire logic rx_out_oe,
  input wire acf_pkg::acf_out_s payload_word,
  input wire logic payload_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Length of the current valid run; must equal one whole cell
  logic [7:0] run_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= 8'h00;
    end else if (payload_valid) begin
      run_q <= run_q + 8'h01;
    end else begin
      run_q <= 8'h00;
    end
  end

  // A cell opens with its marked word and its next three words are unmarked
  sequence s_cell_head;
    payload_word.first ##1 (payload_valid && !payload_word.first)[*3];
  endsequence

  chk_space_reset: assert property ($fell(rst) |-> tx_space_available)
    else $error("space flag low right after reset");
  chk_space_steady: assert property ((!tx_fifo_clk)[*8] |-> $stable(tx_space_available))
    else $error("space flag moved without a writer clock edge");
  chk_gated_off: assert property ((rx_output_float_enable && rx_read_enable_n)[*6] |-> !rx_out_oe)
    else $error("rx outputs driven while not read");
  chk_gated_on: assert property ((rx_output_float_enable && !rx_read_enable_n)[*6] |-> rx_out_oe)
    else $error("rx outputs floating during read");
  chk_float_low: assert property ((!rx_output_float_enable)[*6] |-> rx_out_oe)
    else $error("rx outputs not driven in always-drive mode");
  chk_run_length: assert property ($fell(payload_valid) |-> run_q == 8'(WORDS_PER_CELL))
    else $error("payload run is not one whole cell");
  chk_cell_head: assert property ($rose(payload_valid) |-> s_cell_head)
    else $error("payload cell does not start with its marked word");
  chk_idle_fill: assert property (payload_valid && payload_word.idle |->
    payload_word.data == IDLE_FILL_WORD)
    else $error("idle cell carries wrong fill");
endmodule

bind acf_cell_port acf_cp_chk #(.WORDS_PER_CELL(WORDS_PER_CELL), .IDLE_FILL_WORD(IDLE_FILL_WORD))
  u_chk (.ref_clk, .rst, .tx_fifo_clk, .tx_space_available, .rx_output_float_enable,
  .rx_read_enable_n, .rx_out_oe, .payload_word, .payload_valid);
`default_nettype wire

// *** acf_atm_writer.sv ***
// Behavioural cell writer driving the transmit FIFO pins
`timescale 1ns/1ns
`default_nettype none
module acf_atm_writer (
  input wire logic ref_clk,
  output logic tx_fifo_clk,
  output logic tx_write_enable_n,
  output logic tx_cell_first_word,
  output logic [1:0] tx_word_parity,
  output logic [15:0] tx_cell_word
);
  logic byte_m = 1'b0; // Parity layout, set by the bench
  logic odd_m = 1'b0; // Parity sense, set by the bench

  // Writer clock stands low between words
  initial begin
    tx_fifo_clk = 1'b0;
    tx_write_enable_n = 1'b1;
    tx_cell_first_word = 1'b0;
    tx_word_parity = 2'h0;
    tx_cell_word = 16'h0000;
  end

  // One word per 900 ns period, well under the 52 MHz ceiling
  task automatic put(input logic [15:0] d, input logic wen_n, input logic fw, input logic bad);
    logic [1:0] p;
    p = byte_m ? {^d[15:8], ^d[7:0]} : {^d, 1'b0};
    if (odd_m) begin
      p = ~p;
    end
    @(posedge ref_clk);
    tx_write_enable_n <= wen_n;
    tx_cell_first_word <= fw; // Marker on a cell's first word
    tx_word_parity <= bad ? ~p : p;
    tx_cell_word <= d;
    repeat (4) @(posedge ref_clk);
    tx_fifo_clk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Released lines show the inverse so stale data never looks valid
    tx_fifo_clk <= 1'b0;
    tx_write_enable_n <= 1'b1;
    tx_cell_first_word <= ~fw;
    tx_word_parity <= ~p;
    tx_cell_word <= ~d;
  endtask
endmodule
`default_nettype wire

// *** acf_cell_port_tb.sv ***
// Self-checking bench of the transmit cell FIFO port
`timescale 1ns/1ns
`default_nettype none
module acf_cell_port_tb;
  localparam int WPC = acf_pkg::WORDS_PER_CELL_DEF; // Words in one cell
  localparam int DEP = acf_pkg::FIFO_DEPTH_DEF; // FIFO depth in words
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic rx_output_float_enable = 1'b0;
  logic rx_read_enable_n = 1'b1;
  acf_pkg::acf_word_s rx_src = '0;
  logic cell_slot = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic tx_fifo_clk, tx_write_enable_n, tx_cell_first_word, tx_space_available;
  logic [1:0] tx_word_parity, rx_word_parity;
  logic [15:0] tx_cell_word, rx_cell_word;
  logic rx_cell_first_word, rx_out_oe, payload_valid, irq;
  acf_pkg::acf_out_s payload_word;
  logic [31:0] reg_rdata, v;
  logic [15:0] fq[$]; // Words the FIFO should hold, oldest first
  int err_count = 0;
  int cmp_count = 0;
  integer seed;

  // 10 MHz system clock
  always #50 ref_clk = ~ref_clk;

  acf_cell_port dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .tx_fifo_clk(tx_fifo_clk),
    .tx_write_enable_n(tx_write_enable_n), .tx_cell_first_word(tx_cell_first_word),
    .tx_word_parity(tx_word_parity), .tx_cell_word(tx_cell_word),
    .tx_space_available(tx_space_available), .rx_output_float_enable(rx_output_float_enable),
    .rx_read_enable_n(rx_read_enable_n), .rx_src(rx_src), .rx_cell_word(rx_cell_word),
    .rx_word_parity(rx_word_parity), .rx_cell_first_word(rx_cell_first_word),
    .rx_out_oe(rx_out_oe), .cell_slot(cell_slot), .payload_word(payload_word),
    .payload_valid(payload_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));

  acf_atm_writer w (.ref_clk(ref_clk), .tx_fifo_clk(tx_fifo_clk),
    .tx_write_enable_n(tx_write_enable_n), .tx_cell_first_word(tx_cell_first_word),
    .tx_word_parity(tx_word_parity), .tx_cell_word(tx_cell_word));

  // Closing report, the single end of the run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  // Register read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // One random word written and remembered
  task automatic one(input logic fw, input logic bad);
    logic [15:0] d;
    d = 16'($random(seed));
    w.put(d, 1'b0, fw, bad);
    fq.push_back(d);
  endtask

  // Good words, marker wherever a cell begins
  task automatic fill(input int n);
    repeat (n) one(fq.size() % WPC == 0, 1'b0);
  endtask

  // Offer one insertion slot and check the cell that follows
  task automatic slot();
    int n;
    logic idl;
    logic [15:0] d;
    idl = fq.size() < WPC; // Whole cell or idle
    @(posedge ref_clk);
    cell_slot <= 1'b1;
    @(posedge ref_clk);
    cell_slot <= 1'b0;
    n = 0;
    #1;
    while (payload_valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 20) begin
      err_count++;
      give_verdict();
    end
    for (int i = 0; i < WPC; i++) begin
      d = idl ? 16'h0000 : fq.pop_front();
      chk(32'(payload_word), {14'h0, i == 0, idl, d});
      @(posedge ref_clk);
      #1;
    end
    chk(32'(payload_valid), 32'h0);
  endtask

  // Wait for the interrupt level to settle, then compare
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(irq), 32'(e));
  endtask

  // Space flag moves one cycle after the synced writer edge
  task automatic space_is(input logic e);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(tx_space_available), 32'(e));
  endtask

  // Set the rx pins, let the synchronisers settle, check the drive
  task automatic rxp(input logic fe, input logic rn, input logic e);
    @(posedge ref_clk);
    rx_output_float_enable <= fe;
    rx_read_enable_n <= rn;
    repeat (8) @(posedge ref_clk);
    #1;
    chk(32'(rx_out_oe), 32'(e));
  endtask

  // Main sequence
  initial begin
    seed = 32'h44c2;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(32'(tx_space_available), 32'h1);
    for (int a = 0; a < 20; a += 4) begin
      rd(8'(a), v);
      chk(v, 32'h0); // Reset values, last one unmapped
    end
    slot();
    rd(acf_pkg::REG_STATUS, v);
    chk(v, 32'h8);
    w.put(16'($random(seed)), 1'b1, 1'b1, 1'b0);
    rd(acf_pkg::REG_LEVEL, v);
    chk(v, 32'h0);
    fill(WPC + 5);
    rd(acf_pkg::REG_LEVEL, v);
    chk(v, {16'h1, 16'(WPC + 5)});
    slot();
    slot();
    // Parity and marker faults with interrupt masking
    wr(acf_pkg::REG_STATUS, 32'hf);
    wr(acf_pkg::REG_MASK, 32'h3);
    wr(acf_pkg::REG_CTRL, 32'h3);
    w.byte_m = 1'b1;
    w.odd_m = 1'b1;
    one(1'b0, 1'b1);
    one(1'b1, 1'b0);
    rd(acf_pkg::REG_STATUS, v);
    chk(v, 32'h3);
    irq_is(1'b1);
    wr(acf_pkg::REG_STATUS, 32'h1);
    irq_is(1'b1);
    wr(acf_pkg::REG_STATUS, 32'h2);
    irq_is(1'b0);
    wr(acf_pkg::REG_MASK, 32'h1);
    one(1'b1, 1'b0);
    irq_is(1'b0);
    // Space flag at near-full and full thresholds
    wr(acf_pkg::REG_CTRL, 32'h7);
    fill(DEP - 5 - fq.size());
    space_is(1'b1);
    fill(1);
    space_is(1'b0);
    wr(acf_pkg::REG_CTRL, 32'h3);
    fill(1);
    space_is(1'b1);
    fill(DEP - fq.size());
    space_is(1'b0);
    wr(acf_pkg::REG_STATUS, 32'hf);
    w.put(16'($random(seed)), 1'b0, 1'b0, 1'b0);
    rd(acf_pkg::REG_STATUS, v);
    chk(v, 32'h4); // Write into a full FIFO is dropped
    rd(acf_pkg::REG_LEVEL, v);
    chk(v, {16'(DEP / WPC), 16'(DEP)});
    wr(acf_pkg::REG_CTRL, 32'hb);
    w.put(16'h0000, 1'b1, 1'b0, 1'b0);
    space_is(1'b1);
    wr(acf_pkg::REG_CTRL, 32'h3);
    repeat (DEP / WPC) slot();
    // Receive output drive modes and data
    rxp(1'b1, 1'b1, 1'b0);
    rxp(1'b1, 1'b0, 1'b1);
    rxp(1'b0, 1'b1, 1'b1);
    repeat (4) begin
      @(posedge ref_clk);
      rx_src <= acf_pkg::acf_word_s'(19'($random(seed)));
      @(posedge ref_clk);
      #1;
      chk({15'h0, rx_cell_first_word, rx_cell_word}, {15'h0, rx_src.first, rx_src.data});
      chk(32'(rx_word_parity), {30'h0, ~^rx_src.data[15:8], ~^rx_src.data[7:0]});
    end
    // Frozen clock enable must ignore a register write
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(acf_pkg::REG_MASK, 32'hf);
    clk_en <= 1'b1;
    rd(acf_pkg::REG_MASK, v);
    chk(v, 32'h1); // Clock enable freezes state
    give_verdict();
  end
endmodule
`default_nettype wire
